// >>> logic/msg_dump_thermal.sv
// estimated dump transistor temperature, heated while dumping
`timescale 1ns/100ps
`default_nettype none
module msg_dump_thermal #(
	parameter logic [15:0] HEAT_STEP = 16'h0004,
	parameter logic [15:0] COOL_STEP = 16'h0001
) (
	input  wire logic  clk,
	input  wire logic  rst,
	input  wire logic  tick,
	input  wire logic  dumping,
	output logic [15:0] temp,
	output logic       over_limit
);
	logic [15:0] temp_q;
	wire  [16:0] hot = {1'b0, temp_q} + {1'b0, HEAT_STEP};
	// cooling stops at ambient, heating saturates
	wire  [15:0] heated = hot[16] ? 16'hFFFF : hot[15:0];
	wire  [15:0] cooled = (temp_q > msg_pkg::TEMP_AMBIENT + COOL_STEP) ?
		temp_q - COOL_STEP : msg_pkg::TEMP_AMBIENT;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			temp_q <= msg_pkg::TEMP_AMBIENT;
		end else if (tick) begin
			temp_q <= dumping ? heated : cooled;
		end
	end

	assign temp       = temp_q;
	assign over_limit = temp_q > msg_pkg::TEMP_LIMIT;
endmodule
`default_nettype wire

// >>> logic/msg_pkg.sv
// shared constants and types of the motor supply guard and encoder block
package msg_pkg;
	// register offsets
	localparam logic [7:0]  OFS_FEATURE_OPTION_BITS  = 8'h2C;
	localparam logic [7:0]  OFS_FIXED_DUMP_THRESHOLD = 8'h2F;
	localparam logic [7:0]  OFS_DUMP_TRANSISTOR_TEMP = 8'h60;
	localparam logic [7:0]  OFS_REG_MODE             = 8'h80;
	localparam logic [7:0]  OFS_DRIVE_INPUT          = 8'h81;
	localparam logic [7:0]  OFS_NEW_NET_ADDR         = 8'h82;
	localparam logic [7:0]  OFS_NEW_NET_MASK         = 8'h83;
	localparam logic [7:0]  OFS_STATUS               = 8'h84;
	localparam logic [7:0]  OFS_POSITION             = 8'h85;
	// option bit positions
	localparam int          OPT_AUTO_THR_BIT         = 16;
	localparam int          OPT_HALL_POS_BIT         = 17;
	// reset values
	localparam logic [31:0] RST_FEATURE_OPTION_BITS  = 32'h0000_0000;
	localparam logic [15:0] RST_FIXED_DUMP_THRESHOLD = 16'hFFFF;
	localparam logic [31:0] RST_NET_MASK             = 32'hFFFF_0000;
	// supply limits in millivolts
	localparam logic [15:0] UV_TYPE1_MV              = 16'h2EE0;
	localparam logic [15:0] UV_TYPE2_MV              = 16'h1F40;
	localparam logic [15:0] OV_MV                    = 16'hDAC0;
	localparam logic [15:0] AUTO_OFFSET_MV           = 16'h0BB8;
	// temperatures in 1/16 degC
	localparam logic [15:0] TEMP_LIMIT               = 16'h0AA0;
	localparam logic [15:0] TEMP_AMBIENT             = 16'h0190;
	// open-loop drive input range
	localparam logic signed [17:0] DRIVE_MAX         = 18'sh10000;
	localparam logic signed [17:0] DRIVE_MIN         = -18'sh10000;
	// supervision tick
	localparam int          CLK_PERIOD_NS            = 10;
	localparam int          TICK_PERIOD_NS           = 1000;
	localparam int          TICK_CYC                 = TICK_PERIOD_NS / CLK_PERIOD_NS;
	// average filter weight as a shift
	localparam int          AVG_SHIFT                = 4;

	typedef enum logic [2:0] {
		MODE_OPEN_LOOP       = 3'b000,
		MODE_SPEED           = 3'b001,
		MODE_POSITION        = 3'b010,
		MODE_BRAKE           = 3'b011,
		MODE_BRIDGE_RELEASED = 3'b100
	} msg_mode_t;
endpackage

// >>> logic/msg_pos_counter.sv
// quadrature and hall-sensor position counter with sensor presence flags
`timescale 1ns/100ps
`default_nettype none
module msg_pos_counter (
	input  wire logic  clk,
	input  wire logic  rst,
	input  wire logic  enc_a,
	input  wire logic  enc_b,
	input  wire logic  [2:0] hall,
	msg_pos_if.src     pif
);
	logic        a_q;
	logic        b_q;
	logic [2:0]  hidx_q;
	logic [31:0] count_q;
	logic        enc_seen_q;
	logic        hall_seen_q;
	logic        enc_primed_q;

	// hall code to step index, 7 marks an illegal code
	function automatic logic [2:0] hall_index(input logic [2:0] h);
		case (h)
			3'b001:  hall_index = 3'h0;
			3'b011:  hall_index = 3'h1;
			3'b010:  hall_index = 3'h2;
			3'b110:  hall_index = 3'h3;
			3'b100:  hall_index = 3'h4;
			3'b101:  hall_index = 3'h5;
			default: hall_index = 3'h7;
		endcase
	endfunction

	wire         a_edge   = enc_a ^ a_q;
	wire         b_edge   = enc_b ^ b_q;
	// both lines moving at once carries no direction: skipped
	// lines already high at reset release are not taken for a step
	wire         enc_step = (a_edge ^ b_edge) && enc_primed_q;
	wire         enc_up   = a_q ^ enc_b;
	wire [2:0]   hidx     = hall_index(hall);
	wire         hall_ok  = hidx != 3'h7;
	wire [2:0]   hidx_up  = (hidx_q == 3'h5) ? 3'h0 : hidx_q + 3'h1;
	wire [2:0]   hidx_dn  = (hidx_q == 3'h0) ? 3'h5 : hidx_q - 3'h1;
	// first valid code after reset only sets the start index
	wire         hall_prev = hidx_q != 3'h7;
	wire         hall_up  = hall_ok && hall_prev && hidx == hidx_up;
	wire         hall_dn  = hall_ok && hall_prev && hidx == hidx_dn;
	wire         up       = pif.hall_sel ? hall_up : (enc_step && enc_up);
	wire         dn       = pif.hall_sel ? hall_dn : (enc_step && !enc_up);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			a_q         <= 1'b0;
			b_q         <= 1'b0;
			hidx_q      <= 3'h7;
			count_q     <= 32'h0000_0000;
			enc_seen_q  <= 1'b0;
			hall_seen_q <= 1'b0;
			enc_primed_q <= 1'b0;
		end else begin
			enc_primed_q <= 1'b1;
			a_q         <= enc_a;
			b_q         <= enc_b;
			hidx_q      <= hall_ok ? hidx : hidx_q;
			count_q     <= up ? count_q + 32'h1 : (dn ? count_q - 32'h1 : count_q);
			enc_seen_q  <= enc_seen_q | enc_step;
			hall_seen_q <= hall_seen_q | (hall_ok && hall_prev && hidx != hidx_q);
		end
	end

	assign pif.count     = count_q;
	assign pif.enc_seen  = enc_seen_q;
	assign pif.hall_seen = hall_seen_q;
endmodule
`default_nettype wire

// >>> logic/msg_pos_if.sv
// position feedback carrier between the supervisor and the pulse counter
`timescale 1ns/100ps
`default_nettype none
interface msg_pos_if;
	logic [31:0] count;
	logic        enc_seen;
	logic        hall_seen;
	logic        hall_sel;
	modport src (output count, output enc_seen, output hall_seen, input hall_sel);
	modport snk (input count, input enc_seen, input hall_seen, output hall_sel);
endinterface
`default_nettype wire

// >>> logic/msg_supply_guard.sv
// supply guard, braking energy dump, drive mode and network address logic
`timescale 1ns/100ps
`default_nettype none
module msg_supply_guard #(
	parameter logic [31:0] FACTORY_NET_ADDR = 32'hC0A8_0001, // arbitrary value
	parameter logic [15:0] HEAT_STEP        = 16'h0004,
	parameter logic [15:0] COOL_STEP        = 16'h0001
) (
	input  wire logic        CORE_CLK,
	input  wire logic        SYS_RST,
	input  wire logic        HW_TYPE2,
	input  wire logic [15:0] SUPPLY_MV,
	input  wire logic        ENC_A,
	input  wire logic        ENC_B,
	input  wire logic [2:0]  HALL,
	input  wire logic        TCP_OPEN,
	input  wire logic        RECOVERY_BTN,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	output logic [31:0]      REG_RDATA,
	output logic             REG_ACK,
	output logic [2:0]       DRIVE_MODE,
	output logic [17:0]      DRIVE_CMD,
	output logic             DUMP_ON,
	output logic             CLOSED_LOOP_OK,
	output logic             MOTOR_BRUSHLESS,
	output logic [31:0]      NET_ADDR,
	output logic [31:0]      NET_MASK,
	output logic             NV_SAVE
);
	msg_pos_if pif ();

	// strap and tick
	logic        strap_done_q;
	logic        type2_q;
	logic [7:0]  tick_cnt_q;
	logic        tick_q;

	// registers
	logic [31:0] feature_option_bits_q;
	logic [15:0] fixed_thr_q;
	logic [2:0]  mode_q;
	logic signed [17:0] drive_in_q;
	logic [17:0] drive_cmd_q;
	logic [31:0] new_addr_q;
	logic [31:0] new_mask_q;
	logic        addr_pend_q;
	logic [31:0] net_addr_q;
	logic [31:0] net_mask_q;
	logic        nv_save_q;
	logic        btn_q;
	logic [31:0] rdata_q;
	logic        ack_q;

	// supply average
	logic [19:0] avg_acc_q;
	logic        avg_seeded_q;
	logic        dump_q;

	// temperature
	logic [15:0] temp;
	logic        over_temp;

	// write strobes
	wire wr_opt   = REG_WR && REG_ADDR == msg_pkg::OFS_FEATURE_OPTION_BITS;
	wire wr_thr   = REG_WR && REG_ADDR == msg_pkg::OFS_FIXED_DUMP_THRESHOLD;
	wire wr_mode  = REG_WR && REG_ADDR == msg_pkg::OFS_REG_MODE;
	wire wr_drive = REG_WR && REG_ADDR == msg_pkg::OFS_DRIVE_INPUT;
	wire wr_addr  = REG_WR && REG_ADDR == msg_pkg::OFS_NEW_NET_ADDR;
	wire wr_mask  = REG_WR && REG_ADDR == msg_pkg::OFS_NEW_NET_MASK;

	// supply supervision
	wire [15:0] uv_limit = type2_q ? msg_pkg::UV_TYPE2_MV : msg_pkg::UV_TYPE1_MV;
	wire        ov_now   = SUPPLY_MV > msg_pkg::OV_MV;
	wire        uv_now   = SUPPLY_MV < uv_limit;
	wire        fault    = ov_now || uv_now;

	// motor detection: valid hall activity means brushless
	wire brushless  = pif.hall_seen;
	wire loop_ok    = pif.enc_seen || (brushless && pif.hall_sel);
	assign pif.hall_sel = feature_option_bits_q[msg_pkg::OPT_HALL_POS_BIT] && brushless;

	// requested mode after the feedback check
	wire [2:0] req_mode = REG_WDATA[2:0];
	wire       req_loop = req_mode == msg_pkg::MODE_SPEED ||
		req_mode == msg_pkg::MODE_POSITION;
	logic [2:0] mode_d;
	always_comb begin
		mode_d = mode_q;
		if (ov_now) begin
			mode_d = msg_pkg::MODE_BRIDGE_RELEASED;
		end else if (uv_now) begin
			mode_d = msg_pkg::MODE_BRAKE;
		end else if (wr_mode) begin
			// forced mode is left only by this write, after the fault is gone
			case (req_mode)
				msg_pkg::MODE_OPEN_LOOP,
				msg_pkg::MODE_BRAKE,
				msg_pkg::MODE_BRIDGE_RELEASED: begin
					mode_d = req_mode;
				end
				msg_pkg::MODE_SPEED,
				msg_pkg::MODE_POSITION: begin
					mode_d = loop_ok ? req_mode : msg_pkg::MODE_OPEN_LOOP;
				end
				default: begin
					mode_d = mode_q;
				end
			endcase
		end
	end

	// open-loop input clamp
	wire signed [31:0] win      = $signed(REG_WDATA);
	wire signed [17:0] drive_cl = (win > 32'sd65536) ? msg_pkg::DRIVE_MAX :
		(win < -32'sd65536) ? msg_pkg::DRIVE_MIN : win[17:0];
	wire        open_loop = mode_q == msg_pkg::MODE_OPEN_LOOP;
	wire [17:0] drive_d   = open_loop ? drive_in_q : 18'h00000;

	// dump threshold
	wire [15:0] avg_mv    = avg_acc_q[19:msg_pkg::AVG_SHIFT];
	wire [16:0] auto_thr  = {1'b0, avg_mv} + {1'b0, msg_pkg::AUTO_OFFSET_MV};
	wire        auto_mode = feature_option_bits_q[msg_pkg::OPT_AUTO_THR_BIT];
	wire [16:0] act_thr   = auto_mode ? auto_thr : {1'b0, fixed_thr_q};
	// a fast rise outruns the slow average and crosses the threshold
	wire        dump_req  = {1'b0, SUPPLY_MV} > act_thr;
	wire [19:0] avg_step  = avg_acc_q + {4'h0, SUPPLY_MV} - {4'h0, avg_mv};

	// network address
	wire        btn_press  = RECOVERY_BTN && !btn_q;
	// a staged word written in this cycle is applied one cycle later
	wire        addr_apply = addr_pend_q && !TCP_OPEN && !btn_press && !wr_addr && !wr_mask;

	// read mux
	logic [31:0] rd_d;
	always_comb begin
		case (REG_ADDR)
			msg_pkg::OFS_FEATURE_OPTION_BITS:  rd_d = feature_option_bits_q;
			msg_pkg::OFS_FIXED_DUMP_THRESHOLD: rd_d = {16'h0000, fixed_thr_q};
			msg_pkg::OFS_DUMP_TRANSISTOR_TEMP: rd_d = {16'h0000, temp};
			msg_pkg::OFS_REG_MODE:             rd_d = {29'h0, mode_q};
			msg_pkg::OFS_DRIVE_INPUT:          rd_d = {{14{drive_in_q[17]}}, drive_in_q};
			msg_pkg::OFS_NEW_NET_ADDR:         rd_d = new_addr_q;
			msg_pkg::OFS_NEW_NET_MASK:         rd_d = new_mask_q;
			msg_pkg::OFS_STATUS:               rd_d = {24'h0, addr_pend_q, over_temp,
				dump_q, loop_ok, brushless, pif.enc_seen, ov_now, uv_now};
			msg_pkg::OFS_POSITION:             rd_d = pif.count;
			default:                           rd_d = 32'h0000_0000;
		endcase
	end

	msg_pos_counter u_pos (
		.clk    (CORE_CLK),
		.rst    (SYS_RST),
		.enc_a  (ENC_A),
		.enc_b  (ENC_B),
		.hall   (HALL),
		.pif    (pif)
	);

	msg_dump_thermal #(
		.HEAT_STEP (HEAT_STEP),
		.COOL_STEP (COOL_STEP)
	) u_therm (
		.clk        (CORE_CLK),
		.rst        (SYS_RST),
		.tick       (tick_q),
		.dumping    (dump_q),
		.temp       (temp),
		.over_limit (over_temp)
	);

	// hardware type strap, caught once after reset release
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			strap_done_q <= 1'b0;
			type2_q      <= 1'b0;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			type2_q      <= HW_TYPE2;
		end
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			tick_cnt_q <= 8'h00;
			tick_q     <= 1'b0;
		end else begin
			tick_q     <= tick_cnt_q == 8'(msg_pkg::TICK_CYC - 1);
			tick_cnt_q <= (tick_cnt_q == 8'(msg_pkg::TICK_CYC - 1)) ? 8'h00 : tick_cnt_q + 8'h01;
		end
	end

	// control registers
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			feature_option_bits_q   <= msg_pkg::RST_FEATURE_OPTION_BITS;
			fixed_thr_q <= msg_pkg::RST_FIXED_DUMP_THRESHOLD;
			mode_q      <= msg_pkg::MODE_BRAKE;
			drive_in_q  <= 18'sh00000;
			drive_cmd_q <= 18'h00000;
		end else begin
			if (wr_opt)
				feature_option_bits_q <= REG_WDATA;
			if (wr_thr)
				fixed_thr_q <= REG_WDATA[15:0];
			if (wr_drive)
				drive_in_q <= drive_cl;
			mode_q      <= mode_d;
			drive_cmd_q <= drive_d;
		end
	end

	// supply average and dump output
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			avg_acc_q    <= 20'h00000;
			avg_seeded_q <= 1'b0;
			dump_q       <= 1'b0;
		end else begin
			if (tick_q) begin
				// seeding avoids a dump burst while the average climbs from zero
				avg_acc_q    <= avg_seeded_q ? avg_step : {SUPPLY_MV, 4'h0};
				avg_seeded_q <= 1'b1;
			end
			dump_q <= dump_req && !over_temp && (avg_seeded_q || !auto_mode);
		end
	end

	// network address handling
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			new_addr_q  <= FACTORY_NET_ADDR;
			new_mask_q  <= msg_pkg::RST_NET_MASK;
			addr_pend_q <= 1'b0;
			net_addr_q  <= FACTORY_NET_ADDR;
			net_mask_q  <= msg_pkg::RST_NET_MASK;
			nv_save_q   <= 1'b0;
			btn_q       <= 1'b0;
		end else begin
			btn_q     <= RECOVERY_BTN;
			nv_save_q <= addr_apply;
			if (wr_mask)
				new_mask_q <= REG_WDATA;
			// a write in the press cycle stays pending: the set wins
			addr_pend_q <= wr_addr || (addr_pend_q && !addr_apply && !btn_press);
			if (wr_addr)
				new_addr_q <= REG_WDATA;
			if (btn_press) begin
				net_addr_q <= FACTORY_NET_ADDR;
			end else if (addr_apply) begin
				net_addr_q <= new_addr_q;
				net_mask_q <= new_mask_q;
			end
		end
	end

	// register port answer
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rdata_q <= 32'h0000_0000;
			ack_q   <= 1'b0;
		end else begin
			ack_q   <= REG_WR || REG_RD;
			rdata_q <= REG_RD ? rd_d : rdata_q;
		end
	end

	assign REG_RDATA       = rdata_q;
	assign REG_ACK         = ack_q;
	assign DRIVE_MODE      = mode_q;
	assign DRIVE_CMD       = drive_cmd_q;
	assign DUMP_ON         = dump_q;
	assign CLOSED_LOOP_OK  = loop_ok;
	assign MOTOR_BRUSHLESS = brushless;
	assign NET_ADDR        = net_addr_q;
	assign NET_MASK        = net_mask_q;
	assign NV_SAVE         = nv_save_q;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);

	sequence s_over_v;
		ov_now;
	endsequence
	sequence s_under_v;
		uv_now && !ov_now;
	endsequence
	sequence s_cooled_with_demand;
		$fell(over_temp) && dump_req && (avg_seeded_q || !auto_mode);
	endsequence

	a_ov_release: assert property (s_over_v |=> mode_q == msg_pkg::MODE_BRIDGE_RELEASED)
		else $error("overvoltage did not release the bridge");
	a_uv_brake: assert property (s_under_v |=> mode_q == msg_pkg::MODE_BRAKE)
		else $error("undervoltage did not force brake");
	a_fault_hold: assert property (
		mode_q == msg_pkg::MODE_BRAKE && !wr_mode |=> mode_q == msg_pkg::MODE_BRAKE ||
		mode_q == msg_pkg::MODE_BRIDGE_RELEASED)
		else $error("brake mode left without a mode write");
	a_dump_follow: assert property (dump_req && !over_temp && avg_seeded_q |=> DUMP_ON)
		else $error("dump stage not on above threshold");
	a_dump_hot: assert property (over_temp |=> !DUMP_ON)
		else $error("dump stage on while over temperature");
	a_dump_resume: assert property (s_cooled_with_demand |=> DUMP_ON)
		else $error("dump stage not resumed after cooling");
	a_thr_auto: assert property (auto_mode |-> act_thr == {1'b0, avg_mv} + 17'h00BB8)
		else $error("automatic threshold not average plus offset");
	a_loop_gate: assert property (!loop_ok && !$past(loop_ok) |->
		mode_q != msg_pkg::MODE_SPEED && mode_q != msg_pkg::MODE_POSITION)
		else $error("regulation mode without feedback");
	a_mode_fallback: assert property (wr_mode && !fault && req_loop && !loop_ok |=>
		mode_q == msg_pkg::MODE_OPEN_LOOP)
		else $error("regulation request without feedback not refused");
	a_addr_hold: assert property (TCP_OPEN && !btn_press |=> $stable(NET_ADDR))
		else $error("address changed while connected");
	a_addr_save: assert property (addr_apply |=> NV_SAVE && NET_ADDR == $past(new_addr_q))
		else $error("applied address not saved");
	a_addr_recover: assert property (btn_press && !wr_addr |=>
		NET_ADDR == FACTORY_NET_ADDR ##1 !NV_SAVE)
		else $error("recovery button did not restore address");
	a_open_cmd: assert property (open_loop |=> DRIVE_CMD == $past(drive_in_q))
		else $error("open-loop command not applied");
endmodule
`default_nettype wire

// >>> sim/msg_host_model.sv
// host side model: register accesses as sent over the network link
`timescale 1ns/100ps
`default_nettype none
module msg_host_model (
	input  wire logic        clk,
	output logic             wr,
	output logic             rd,
	output logic [7:0]       addr,
	output logic [31:0]      wdata,
	input  wire logic [31:0] rdata,
	input  wire logic        ack
);
	logic [31:0] last_data;
	logic        last_ack;
	initial begin
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
	end
	// one-cycle strobe, answer taken at the edge after the ack cycle starts
	task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		#1;
		wr = w;
		rd = ~w;
		addr = a;
		wdata = d;
		@(posedge clk);
		#1;
		wr = 1'b0;
		rd = 1'b0;
		// released lines must not keep looking valid
		addr = ~a;
		wdata = ~d;
		@(posedge clk);
		last_ack = ack;
		last_data = rdata;
		#1;
	endtask
	// threshold is lost at power-up, so it is sent again after the last reset
	task automatic set_fixed_threshold(input logic [31:0] d);
		access(1'b1, msg_pkg::OFS_FIXED_DUMP_THRESHOLD, d);
	endtask
	task automatic put_drive(input int v);
		int c;
		c = v > int'(msg_pkg::DRIVE_MAX) ? int'(msg_pkg::DRIVE_MAX) : v;
		c = c < int'(msg_pkg::DRIVE_MIN) ? int'(msg_pkg::DRIVE_MIN) : c;
		access(1'b1, msg_pkg::OFS_DRIVE_INPUT, 32'(c));
	endtask
endmodule
`default_nettype wire

// >>> sim/msg_supply_guard_test.sv
// self-checking bench of the supply guard, dump and position logic
`timescale 1ns/100ps
`default_nettype none
module msg_supply_guard_test;
	localparam logic [31:0] FACT = 32'hC0A8_0001; // arbitrary value
	logic        core_clk, sys_rst, hw_type2, enc_a, enc_b, tcp_open, rec_btn;
	logic        reg_wr, reg_rd, reg_ack, dump_on, loop_ok, brushless, nv_save;
	logic [15:0] supply_mv, lo;
	logic [2:0]  hall, drive_mode;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, net_addr, net_mask, rng;
	logic [17:0] drive_cmd;
	logic [1:0]  ab, nab;
	logic [2:0]  hall_seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
	logic [31:0] net_q [$];
	int          bad_count, checked, pos, v, hi, n;

	msg_supply_guard #(.FACTORY_NET_ADDR(FACT), .HEAT_STEP(16'h0100), .COOL_STEP(16'h0010))
	msg_supply_guard_i (
		.CORE_CLK(core_clk), .SYS_RST(sys_rst), .HW_TYPE2(hw_type2), .SUPPLY_MV(supply_mv),
		.ENC_A(enc_a), .ENC_B(enc_b), .HALL(hall), .TCP_OPEN(tcp_open),
		.RECOVERY_BTN(rec_btn), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_ACK(reg_ack),
		.DRIVE_MODE(drive_mode), .DRIVE_CMD(drive_cmd), .DUMP_ON(dump_on),
		.CLOSED_LOOP_OK(loop_ok), .MOTOR_BRUSHLESS(brushless), .NET_ADDR(net_addr),
		.NET_MASK(net_mask), .NV_SAVE(nv_save));
	msg_host_model host_i (.clk(core_clk), .wr(reg_wr), .rd(reg_rd), .addr(reg_addr),
		.wdata(reg_wdata), .rdata(reg_rdata), .ack(reg_ack));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic complete_run();
		if (bad_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host_i.access(1'b1, a, d);
		check(32'(host_i.last_ack), 32'h1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		host_i.access(1'b0, a, 32'h0000_0000);
		check(host_i.last_data, e);
		check(32'(host_i.last_ack), 32'h1);
	endtask
	task automatic mode_is(input logic [2:0] m);
		check(32'(drive_mode), 32'(m));
	endtask
	task automatic wait_dump(input logic lvl, input int lim);
		n = 0;
		while (dump_on !== lvl && n < lim) begin
			step(1);
			n++;
		end
		check(32'(dump_on), 32'(lvl));
		if (dump_on !== lvl) complete_run();
	endtask
	task automatic do_reset(input logic t2);
		sys_rst = 1'b1;
		hw_type2 = t2;
		step(2);
		sys_rst = 1'b0;
		step(1);
	endtask

	initial begin
		bad_count = 0;
		checked = 0;
		rng = 32'h0000_DE98;
		sys_rst = 1'b1;
		hw_type2 = 1'b0;
		supply_mv = 16'h5DC0;
		{enc_a, enc_b, tcp_open, rec_btn} = 4'h0;
		hall = 3'h0;
		do_reset(1'b0);
		mode_is(msg_pkg::MODE_BRAKE);
		check(net_addr, FACT);
		check(32'({loop_ok, brushless}), 32'h0);
		rd(msg_pkg::OFS_FEATURE_OPTION_BITS, 32'h0000_0000);
		rd(msg_pkg::OFS_FIXED_DUMP_THRESHOLD, 32'h0000_FFFF);
		rd(msg_pkg::OFS_DUMP_TRANSISTOR_TEMP, 32'(msg_pkg::TEMP_AMBIENT));
		rd(8'h10, 32'h0000_0000);
		rd(msg_pkg::OFS_STATUS, 32'h0000_0000);
		wr(msg_pkg::OFS_REG_MODE, 32'h1);
		mode_is(msg_pkg::MODE_OPEN_LOOP);
		for (int i = 0; i < 6; i++) begin
			rng = xs(rng);
			v = i == 0 ? int'(msg_pkg::DRIVE_MAX) : i == 1 ? int'(msg_pkg::DRIVE_MIN) :
				int'(rng[16:0]) - 65536;
			host_i.put_drive(v);
			check(32'($signed(drive_cmd)), 32'(v));
		end
		wr(msg_pkg::OFS_DRIVE_INPUT, 32'hFFFD_0000);
		check(32'($signed(drive_cmd)), 32'(int'(msg_pkg::DRIVE_MIN)));
		rd(msg_pkg::OFS_DRIVE_INPUT, 32'hFFFF_0000);
		wr(msg_pkg::OFS_REG_MODE, 32'h4);
		mode_is(msg_pkg::MODE_BRIDGE_RELEASED);
		wr(msg_pkg::OFS_REG_MODE, 32'h7);
		mode_is(msg_pkg::MODE_BRIDGE_RELEASED);
		check(32'(drive_cmd), 32'h0);
		wr(msg_pkg::OFS_REG_MODE, 32'h3);
		rd(msg_pkg::OFS_REG_MODE, 32'(msg_pkg::MODE_BRAKE));
		// the type strap only counts at reset, so each type gets its own
		for (int t = 0; t < 2; t++) begin
			do_reset(t[0]);
			lo = t ? msg_pkg::UV_TYPE2_MV : msg_pkg::UV_TYPE1_MV;
			wr(msg_pkg::OFS_REG_MODE, 32'h0);
			mode_is(msg_pkg::MODE_OPEN_LOOP);
			supply_mv = msg_pkg::UV_TYPE1_MV - 16'h1;
			step(1);
			mode_is(t ? msg_pkg::MODE_OPEN_LOOP : msg_pkg::MODE_BRAKE);
			supply_mv = lo - 16'h1;
			step(1);
			mode_is(msg_pkg::MODE_BRAKE);
			wr(msg_pkg::OFS_REG_MODE, 32'h0);
			mode_is(msg_pkg::MODE_BRAKE);
			supply_mv = lo;
			step(2);
			mode_is(msg_pkg::MODE_BRAKE);
			wr(msg_pkg::OFS_REG_MODE, 32'h0);
			mode_is(msg_pkg::MODE_OPEN_LOOP);
			supply_mv = msg_pkg::OV_MV + 16'h1;
			step(1);
			mode_is(msg_pkg::MODE_BRIDGE_RELEASED);
			supply_mv = msg_pkg::OV_MV;
			wr(msg_pkg::OFS_REG_MODE, 32'h0);
			mode_is(msg_pkg::MODE_OPEN_LOOP);
			supply_mv = 16'h5DC0;
		end
		host_i.set_fixed_threshold(32'h0000_7530);
		supply_mv = 16'h7531;
		step(1);
		check(32'(dump_on), 32'h1);
		supply_mv = 16'h7530;
		step(1);
		check(32'(dump_on), 32'h0);
		supply_mv = 16'h4E20;
		wr(msg_pkg::OFS_FEATURE_OPTION_BITS, 32'h0001_0000);
		// long settle so the average no longer remembers earlier supplies
		step(8000);
		check(32'(dump_on), 32'h0);
		supply_mv = 16'h5BCC;
		step(1);
		check(32'(dump_on), 32'h1);
		wait_dump(1'b0, 2000);
		host_i.access(1'b0, msg_pkg::OFS_DUMP_TRANSISTOR_TEMP, 32'h0000_0000);
		check(32'(host_i.last_data > 32'(msg_pkg::TEMP_AMBIENT)), 32'h1);
		wr(msg_pkg::OFS_FEATURE_OPTION_BITS, 32'h0000_0000);
		supply_mv = 16'h7531;
		wait_dump(1'b1, 3);
		wait_dump(1'b0, 3000);
		host_i.access(1'b0, msg_pkg::OFS_DUMP_TRANSISTOR_TEMP, 32'h0000_0000);
		check(32'(host_i.last_data > 32'(msg_pkg::TEMP_LIMIT)), 32'h1);
		wait_dump(1'b1, 3000);
		supply_mv = 16'h5DC0;
		host_i.access(1'b0, msg_pkg::OFS_POSITION, 32'h0000_0000);
		pos = int'(host_i.last_data);
		ab = 2'b00;
		for (int i = 0; i < 40; i++) begin
			rng = xs(rng);
			nab = rng[0] ? {ab[0], ~ab[1]} : {~ab[0], ab[1]};
			pos += (ab[1] != nab[0]) ? 1 : -1;
			ab = nab;
			{enc_a, enc_b} = ab;
			step(2);
		end
		rd(msg_pkg::OFS_POSITION, 32'(pos));
		check(32'(loop_ok), 32'h1);
		wr(msg_pkg::OFS_REG_MODE, 32'h2);
		mode_is(msg_pkg::MODE_POSITION);
		check(32'(brushless), 32'h0);
		wr(msg_pkg::OFS_FEATURE_OPTION_BITS, 32'h0002_0000);
		hall = 3'h1;
		step(2);
		hall = 3'h3;
		step(2);
		check(32'(brushless), 32'h1);
		host_i.access(1'b0, msg_pkg::OFS_POSITION, 32'h0000_0000);
		pos = int'(host_i.last_data);
		hi = 1;
		for (int i = 0; i < 8; i++) begin
			hi = i < 6 ? (hi + 1) % 6 : (hi + 5) % 6;
			pos += i < 6 ? 1 : -1;
			hall = hall_seq[hi];
			step(2);
		end
		rd(msg_pkg::OFS_POSITION, 32'(pos));
		tcp_open = 1'b1;
		net_q.push_back(32'h0A00_0002);
		wr(msg_pkg::OFS_NEW_NET_MASK, 32'hFFFF_FF00);
		wr(msg_pkg::OFS_NEW_NET_ADDR, net_q[0]);
		step(4);
		check(net_addr, FACT);
		check(32'(nv_save), 32'h0);
		tcp_open = 1'b0;
		n = 0;
		while (nv_save !== 1'b1 && n < 5) begin
			step(1);
			n++;
		end
		check(32'(nv_save), 32'h1);
		if (nv_save !== 1'b1) complete_run();
		check(net_addr, net_q.pop_front());
		check(net_mask, 32'hFFFF_FF00);
		step(1);
		check(32'(nv_save), 32'h0);
		rec_btn = 1'b1;
		step(2);
		check(net_addr, FACT);
		check(net_mask, 32'hFFFF_FF00);
		rec_btn = 1'b0;
		step(2);
		complete_run();
	end
endmodule
`default_nettype wire
